// ===== cable_diag_pkg.sv
// Constants for the cable diagnostic result register bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, word aligned.
package cable_diag_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PEAK_AMP_TX5_RX1 = 10'h187;
  localparam logic [9:0] IDX_PEAK_AMP_RX2_RX3 = 10'h188;
  localparam logic [9:0] IDX_PEAK_AMP_RX4_RX5 = 10'h189;
  localparam logic [9:0] IDX_GENERAL_DIAG_FLAGS = 10'h18a;
  localparam logic [9:0] IDX_DIAG_STATE = 10'h190;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h191;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h192;
  localparam logic [9:0] IDX_CAPTURE_CTRL = 10'h193;

  // Amplitude register fields
  localparam int AMP_W = 7;
  localparam int AMP_HI_LSB = 8;
  localparam int AMP_LO_LSB = 0;
  localparam int AMP_RSVD_HI = 15;
  localparam int AMP_RSVD_LO = 7;

  // General flags register fields
  localparam int GEN_TX_POL_LSB = 11;
  localparam int GEN_RX_POL_LSB = 6;
  localparam int GEN_CROSS_TX = 5;
  localparam int GEN_CROSS_RX = 4;
  localparam int GEN_OVER5_TX = 3;
  localparam int GEN_OVER5_RX = 2;

  // Diagnostic state register fields
  localparam int ST_RESULTS_VALID = 0;
  localparam int ST_CAPTURE_EN = 1;
  localparam int ST_RUN_COUNT_LSB = 8;

  // Interrupt event bits
  localparam int IRQ_N = 4;
  localparam int EV_RUN_DONE = 0;
  localparam int EV_CROSS = 1;
  localparam int EV_OVER5 = 2;
  localparam int EV_MISSED = 3;

  // Capture control fields
  localparam int CTRL_CAPTURE_EN = 0;
  localparam int CTRL_CLEAR = 1;

  // Reset values
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [IRQ_N-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic RST_CAPTURE_EN = 1'b1;
  localparam logic [7:0] RST_RUN_COUNT = 8'h00;

endpackage : cable_diag_pkg

// ===== diag_result_bank.sv
// Result holding registers of the cable diagnostic.
// Assumes engine result inputs are stable in the cycle of the load pulse.
`timescale 1ns/1ps
module diag_result_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Load and clear
  input wire logic load,
  input wire logic clear,
  // Engine results
  input wire logic [6:0] tx_peak5_amp,
  input wire logic [34:0] rx_peak_amp,
  input wire logic [4:0] tx_peak_pol,
  input wire logic [4:0] rx_peak_pol,
  input wire logic cross_tx,
  input wire logic cross_rx,
  input wire logic over5_tx,
  input wire logic over5_rx,
  // Register words
  output logic [15:0] amp_tx5_rx1,
  output logic [15:0] amp_rx2_rx3,
  output logic [15:0] amp_rx4_rx5,
  output logic [15:0] gen_flags
);

  logic [15:0] amp_tx5_rx1_ff;
  logic [15:0] amp_rx2_rx3_ff;
  logic [15:0] amp_rx4_rx5_ff;
  logic [15:0] gen_flags_ff;

  // Reserved bits 15 and 7 always zero
  function automatic logic [15:0] amp_word(input logic [6:0] hi,
                                           input logic [6:0] lo);
    logic [15:0] w;
    w = cable_diag_pkg::RST_RESULT;
    w[cable_diag_pkg::AMP_HI_LSB +: cable_diag_pkg::AMP_W] = hi;
    w[cable_diag_pkg::AMP_LO_LSB +: cable_diag_pkg::AMP_W] = lo;
    w[cable_diag_pkg::AMP_RSVD_HI] = 1'b0;
    w[cable_diag_pkg::AMP_RSVD_LO] = 1'b0;
    return w;
  endfunction : amp_word

  function automatic logic [6:0] rx_amp(input logic [34:0] v,
                                        input int n);
    return v[7*(n-1) +: 7];
  endfunction : rx_amp

  // Hold until the next finished run or a clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      amp_tx5_rx1_ff <= cable_diag_pkg::RST_RESULT;
      amp_rx2_rx3_ff <= cable_diag_pkg::RST_RESULT;
      amp_rx4_rx5_ff <= cable_diag_pkg::RST_RESULT;
      gen_flags_ff <= cable_diag_pkg::RST_RESULT;
    end else if (clear) begin
      amp_tx5_rx1_ff <= cable_diag_pkg::RST_RESULT;
      amp_rx2_rx3_ff <= cable_diag_pkg::RST_RESULT;
      amp_rx4_rx5_ff <= cable_diag_pkg::RST_RESULT;
      gen_flags_ff <= cable_diag_pkg::RST_RESULT;
    end else if (load) begin
      amp_tx5_rx1_ff <= amp_word(rx_amp(rx_peak_amp, 1),
                                 tx_peak5_amp);
      amp_rx2_rx3_ff <= amp_word(rx_amp(rx_peak_amp, 3),
                                 rx_amp(rx_peak_amp, 2));
      amp_rx4_rx5_ff <= amp_word(rx_amp(rx_peak_amp, 5),
                                 rx_amp(rx_peak_amp, 4));
      gen_flags_ff <= {tx_peak_pol,
                       rx_peak_pol,
                       cross_tx,
                       cross_rx,
                       over5_tx, over5_rx, 2'b00};
    end
  end

  assign amp_tx5_rx1 = amp_tx5_rx1_ff;
  assign amp_rx2_rx3 = amp_rx2_rx3_ff;
  assign amp_rx4_rx5 = amp_rx4_rx5_ff;
  assign gen_flags = gen_flags_ff;

endmodule : diag_result_bank

// ===== diag_irq_unit.sv
// Sticky event status, mask and level interrupt.
// Assumes clear bits come from a single accepted bus write.
`timescale 1ns/1ps
module diag_irq_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Events and software control
  input wire logic [cable_diag_pkg::IRQ_N-1:0] event_set,
  input wire logic [cable_diag_pkg::IRQ_N-1:0] clear_bits,
  input wire logic mask_we,
  input wire logic [cable_diag_pkg::IRQ_N-1:0] mask_wdata,
  // State
  output logic [cable_diag_pkg::IRQ_N-1:0] status,
  output logic [cable_diag_pkg::IRQ_N-1:0] mask,
  output logic irq
);

  logic [cable_diag_pkg::IRQ_N-1:0] status_ff;
  logic [cable_diag_pkg::IRQ_N-1:0] nxt_status;
  logic [cable_diag_pkg::IRQ_N-1:0] mask_ff;
  logic irq_ff;

  // New event wins over a clear in the same cycle
  assign nxt_status = (status_ff & ~clear_bits) | event_set;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= cable_diag_pkg::RST_IRQ_MASK;
    end else if (mask_we) begin
      mask_ff <= mask_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = irq_ff;

endmodule : diag_irq_unit

// ===== cable_diag_amplitude_results.sv
// Cable diagnostic amplitude and general result register bank.
// Assumes an Avalon-MM master with byte addresses, one clock domain,
// and a diagnostic engine that pulses diag_done with results stable.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module cable_diag_amplitude_results (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Diagnostic engine results
  input wire logic diag_done,
  input wire logic [6:0] tx_peak5_amp,
  input wire logic [34:0] rx_peak_amp,
  input wire logic [4:0] tx_peak_pol,
  input wire logic [4:0] rx_peak_pol,
  input wire logic cross_tx,
  input wire logic cross_rx,
  input wire logic over5_tx,
  input wire logic over5_rx,
  // Interrupt
  output logic irq
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;

  bus_state_e bus_state_ff;
  bus_state_e nxt_bus_state;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic waitrequest_ff;
  logic [9:0] word_idx;
  logic req;
  logic wr_commit;
  logic capture_en_ff;
  logic results_valid_ff;
  logic [7:0] run_count_ff;
  logic load;
  logic clear_cmd;
  logic [15:0] amp_tx5_rx1;
  logic [15:0] amp_rx2_rx3;
  logic [15:0] amp_rx4_rx5;
  logic [15:0] gen_flags;
  logic [cable_diag_pkg::IRQ_N-1:0] event_set;
  logic [cable_diag_pkg::IRQ_N-1:0] irq_clear;
  logic [cable_diag_pkg::IRQ_N-1:0] irq_status;
  logic [cable_diag_pkg::IRQ_N-1:0] irq_mask;
  logic mask_we;
  logic [15:0] diag_state;

  // Write data of the low two byte lanes, lanes not enabled kept
  function automatic logic [15:0] merge_lo(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = wd[7:0];
    end
    if (be[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction : merge_lo

  function automatic logic hit(input logic [9:0] idx,
                               input logic [9:0] reg_idx);
    return idx == reg_idx;
  endfunction : hit

  assign word_idx = avs_address[11:2];
  assign req = avs_read | avs_write;

  // One wait cycle, then waitrequest low for exactly one cycle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    unique case (bus_state_ff)
      BUS_IDLE: begin
        if (req) begin
          nxt_bus_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_bus_state = BUS_IDLE;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_ff <= BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= (nxt_bus_state != BUS_ACK);
    end
  end

  // A write takes effect at the edge where waitrequest is seen low
  assign wr_commit = avs_write && (bus_state_ff == BUS_ACK);

  assign diag_state = {run_count_ff, 6'h00, capture_en_ff,
                       results_valid_ff};

  // Read mux; unmapped words and upper half read as zero
  always_comb begin
    nxt_readdata = '0;
    if (word_idx == cable_diag_pkg::IDX_PEAK_AMP_TX5_RX1) begin
      nxt_readdata[15:0] = amp_tx5_rx1;
    end else if (hit(word_idx, cable_diag_pkg::IDX_PEAK_AMP_RX2_RX3)) begin
      nxt_readdata[15:0] = amp_rx2_rx3;
    end else if (hit(word_idx, cable_diag_pkg::IDX_PEAK_AMP_RX4_RX5)) begin
      nxt_readdata[15:0] = amp_rx4_rx5;
    end else if (hit(word_idx, cable_diag_pkg::IDX_GENERAL_DIAG_FLAGS)) begin
      nxt_readdata[15:0] = gen_flags;
    end else if (hit(word_idx, cable_diag_pkg::IDX_DIAG_STATE)) begin
      nxt_readdata[15:0] = diag_state;
    end else if (hit(word_idx, cable_diag_pkg::IDX_IRQ_STATUS)) begin
      nxt_readdata[cable_diag_pkg::IRQ_N-1:0] = irq_status;
    end else if (hit(word_idx, cable_diag_pkg::IDX_IRQ_MASK)) begin
      nxt_readdata[cable_diag_pkg::IRQ_N-1:0] = irq_mask;
    end else if (hit(word_idx, cable_diag_pkg::IDX_CAPTURE_CTRL)) begin
      nxt_readdata[cable_diag_pkg::CTRL_CAPTURE_EN] = capture_en_ff;
    end
  end

  // Read data loaded on the request edge, stands through the ack cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_ff <= '0;
    end else if (avs_read && bus_state_ff == BUS_IDLE) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // Capture enable; result registers themselves ignore writes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_en_ff <= cable_diag_pkg::RST_CAPTURE_EN;
    end else if (wr_commit && avs_byteenable[0] &&
                 hit(word_idx, cable_diag_pkg::IDX_CAPTURE_CTRL)) begin
      capture_en_ff <= avs_writedata[cable_diag_pkg::CTRL_CAPTURE_EN];
    end
  end

  // Self-clearing wipe of held results
  assign clear_cmd = wr_commit && avs_byteenable[0] &&
                     hit(word_idx, cable_diag_pkg::IDX_CAPTURE_CTRL) &&
                     avs_writedata[cable_diag_pkg::CTRL_CLEAR];

  // Only a finished run with capture on replaces results
  assign load = diag_done && capture_en_ff && !clear_cmd;

  // Set by a loaded run, cleared by a clear command, for software polling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      results_valid_ff <= 1'b0;
    end else if (load) begin
      results_valid_ff <= 1'b1;
    end else if (clear_cmd) begin
      results_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_count_ff <= cable_diag_pkg::RST_RUN_COUNT;
    end else if (load) begin
      run_count_ff <= run_count_ff + 8'h01;
    end
  end

  always_comb begin
    event_set = '0;
    event_set[cable_diag_pkg::EV_RUN_DONE] = load;
    event_set[cable_diag_pkg::EV_CROSS] = load &&
                                          (cross_tx || cross_rx);
    event_set[cable_diag_pkg::EV_OVER5] = load &&
                                          (over5_tx || over5_rx);
    event_set[cable_diag_pkg::EV_MISSED] = diag_done && !capture_en_ff;
  end

  always_comb begin
    irq_clear = '0;
    if (wr_commit && avs_byteenable[0] &&
        hit(word_idx, cable_diag_pkg::IDX_IRQ_STATUS)) begin
      irq_clear = avs_writedata[cable_diag_pkg::IRQ_N-1:0];
    end
  end

  assign mask_we = wr_commit && avs_byteenable[0] &&
                   hit(word_idx, cable_diag_pkg::IDX_IRQ_MASK);

  diag_result_bank u_results (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(load),
    .clear(clear_cmd),
    .tx_peak5_amp(tx_peak5_amp),
    .rx_peak_amp(rx_peak_amp),
    .tx_peak_pol(tx_peak_pol),
    .rx_peak_pol(rx_peak_pol),
    .cross_tx(cross_tx),
    .cross_rx(cross_rx),
    .over5_tx(over5_tx),
    .over5_rx(over5_rx),
    .amp_tx5_rx1(amp_tx5_rx1),
    .amp_rx2_rx3(amp_rx2_rx3),
    .amp_rx4_rx5(amp_rx4_rx5),
    .gen_flags(gen_flags)
  );

  diag_irq_unit u_irq (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .event_set(event_set),
    .clear_bits(irq_clear),
    .mask_we(mask_we),
    .mask_wdata(avs_writedata[cable_diag_pkg::IRQ_N-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;

endmodule : cable_diag_amplitude_results

// ===== diag_results_assertions.sv
// Checker for bus handshake and result register contents.
// Assumes binding to the result bank top module, one clock.
`timescale 1ns/1ps
module diag_results_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Bus
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Engine and interrupt
  input wire logic diag_done,
  input wire logic [6:0] tx_peak5_amp,
  input wire logic [34:0] rx_peak_amp,
  input wire logic [4:0] tx_peak_pol,
  input wire logic [4:0] rx_peak_pol,
  input wire logic cross_tx,
  input wire logic cross_rx,
  input wire logic over5_tx,
  input wire logic over5_rx,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  logic cap_en_ff;
  logic [15:0] exp_ff [0:3];
  logic [15:0] exp_sel;
  logic [9:0] idx;
  logic [1:0] sel;
  logic ctrl_wr;
  logic rd_ack;
  logic in_bank;
  assign idx = avs_address[11:2];
  // Index 0x187 maps to slot 0
  assign sel = idx[1:0] - 2'h3;
  assign exp_sel = exp_ff[sel];
  assign rd_ack = avs_read && !avs_waitrequest;
  assign in_bank = idx >= cable_diag_pkg::IDX_PEAK_AMP_TX5_RX1 &&
                   idx <= cable_diag_pkg::IDX_GENERAL_DIAG_FLAGS;
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
                   idx == cable_diag_pkg::IDX_CAPTURE_CTRL;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_en_ff <= cable_diag_pkg::RST_CAPTURE_EN;
    end else if (ctrl_wr) begin
      cap_en_ff <= avs_writedata[cable_diag_pkg::CTRL_CAPTURE_EN];
    end
  end
  // Shadow of what each result word must hold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_ff <= '{default: 16'h0000};
    end else if (ctrl_wr && avs_writedata[cable_diag_pkg::CTRL_CLEAR]) begin
      exp_ff <= '{default: 16'h0000};
    end else if (diag_done && cap_en_ff) begin
      exp_ff[0] <= {1'b0, rx_peak_amp[6:0], 1'b0, tx_peak5_amp};
      exp_ff[1] <= {1'b0, rx_peak_amp[20:14], 1'b0, rx_peak_amp[13:7]};
      exp_ff[2] <= {1'b0, rx_peak_amp[34:28], 1'b0, rx_peak_amp[27:21]};
      exp_ff[3] <= {tx_peak_pol, rx_peak_pol, cross_tx, cross_rx,
                    over5_tx, over5_rx, 2'h0};
    end
  end
  chk_ack_follows: assert property (
    $rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  chk_idle_wait: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("acknowledge without request");
  chk_amp_rsvd: assert property (
    rd_ack && in_bank && idx != cable_diag_pkg::IDX_GENERAL_DIAG_FLAGS
    |-> !avs_readdata[15] && !avs_readdata[7])
    else $error("amplitude reserved bit reads one");
  chk_gen_rsvd: assert property (
    rd_ack && idx == cable_diag_pkg::IDX_GENERAL_DIAG_FLAGS
    |-> avs_readdata[1:0] == 2'h0)
    else $error("flags reserved bits read nonzero");
  chk_result_match: assert property (
    rd_ack && in_bank |-> avs_readdata[15:0] == $past(exp_sel))
    else $error("result word differs from last loaded run");
  chk_irq_fall: assert property (
    $fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without a write");
  chk_irq_rise: assert property (
    $rose(irq) |-> $past(diag_done) || $past(diag_done, 2) ||
    $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt raised without a cause");
endmodule : diag_results_chk

bind cable_diag_amplitude_results diag_results_chk u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .diag_done(diag_done), .tx_peak5_amp(tx_peak5_amp),
  .rx_peak_amp(rx_peak_amp), .tx_peak_pol(tx_peak_pol),
  .rx_peak_pol(rx_peak_pol), .cross_tx(cross_tx), .cross_rx(cross_rx),
  .over5_tx(over5_tx), .over5_rx(over5_rx), .irq(irq)
);

// ===== cable_diag_amplitude_results_tb.sv
// Self-checking bench for the diagnostic result register bank.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
module cable_diag_amplitude_results_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic diag_done = 1'b0;
  logic [6:0] tx_peak5_amp = 7'h00;
  logic [34:0] rx_peak_amp = 35'h0;
  logic [4:0] tx_peak_pol = 5'h00;
  logic [4:0] rx_peak_pol = 5'h00;
  logic [3:0] flags = 4'h0;
  logic irq;
  logic [15:0] exp_r [0:3];
  logic [15:0] rd;
  int err_count = 0;
  int total_checks = 0;

  always #5 ref_clk = ~ref_clk;

  cable_diag_amplitude_results dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .diag_done(diag_done), .tx_peak5_amp(tx_peak5_amp),
    .rx_peak_amp(rx_peak_amp), .tx_peak_pol(tx_peak_pol),
    .rx_peak_pol(rx_peak_pol), .cross_tx(flags[3]), .cross_rx(flags[2]),
    .over5_tx(flags[1]), .over5_rx(flags[0]), .irq(irq)
  );

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] idx,
                     input logic [15:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {16'h0, wd};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      wrap_up();
    end
    @(posedge ref_clk);
  endtask : bus

  task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic chk_all;
    for (int i = 0; i < 4; i++) begin
      rdchk(cable_diag_pkg::IDX_PEAK_AMP_TX5_RX1 + 10'(i), exp_r[i]);
    end
  endtask : chk_all

  // Engine pulse, then inputs scrambled so held results show
  task automatic run(input logic ld, input logic [6:0] t5,
                     input logic [34:0] rx, input logic [4:0] tp,
                     input logic [4:0] rp, input logic [3:0] f);
    diag_done <= 1'b1;
    tx_peak5_amp <= t5;
    rx_peak_amp <= rx;
    tx_peak_pol <= tp;
    rx_peak_pol <= rp;
    flags <= f;
    @(posedge ref_clk);
    diag_done <= 1'b0;
    tx_peak5_amp <= ~t5;
    rx_peak_amp <= ~rx;
    tx_peak_pol <= ~tp;
    rx_peak_pol <= ~rp;
    flags <= ~f;
    @(posedge ref_clk);
    if (ld) begin
      exp_r[0] = {1'b0, rx[6:0], 1'b0, t5};
      exp_r[1] = {1'b0, rx[20:14], 1'b0, rx[13:7]};
      exp_r[2] = {1'b0, rx[34:28], 1'b0, rx[27:21]};
      exp_r[3] = {tp, rp, f, 2'h0};
    end
    chk_all();
  endtask : run

  initial begin
    exp_r = '{default: 16'h0000};
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    chk_all();
    check({15'h0, irq}, 16'h0000);
    bus(1'b1, cable_diag_pkg::IDX_IRQ_MASK, 16'h000f);
    rdchk(cable_diag_pkg::IDX_IRQ_MASK, 16'h000f);
    run(1'b1, 7'h7f, '1, 5'h1f, 5'h1f, 4'hf);
    check({15'h0, irq}, 16'h0001);
    // One run loaded: count 1, capture on, results valid
    rdchk(cable_diag_pkg::IDX_DIAG_STATE, 16'h0103);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, cable_diag_pkg::IDX_PEAK_AMP_TX5_RX1 + 10'(i), 16'hffff);
    end
    chk_all();
    run(1'b1, 7'h15, {7'h35, 7'h14, 7'h63, 7'h22, 7'h41}, 5'h16, 5'h0d,
        4'h9);
    run(1'b1, 7'h2a, {7'h4a, 7'h6b, 7'h1c, 7'h5d, 7'h3e}, 5'h09, 5'h12,
        4'h6);
    rdchk(cable_diag_pkg::IDX_IRQ_STATUS, 16'h0007);
    bus(1'b1, cable_diag_pkg::IDX_IRQ_STATUS, 16'h0007);
    rdchk(cable_diag_pkg::IDX_IRQ_STATUS, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    bus(1'b1, cable_diag_pkg::IDX_CAPTURE_CTRL, 16'h0000);
    run(1'b0, 7'h01, 35'h1, 5'h01, 5'h01, 4'h1);
    rdchk(cable_diag_pkg::IDX_IRQ_STATUS, 16'h0008);
    check({15'h0, irq}, 16'h0001);
    bus(1'b1, cable_diag_pkg::IDX_IRQ_MASK, 16'h0007);
    rdchk(cable_diag_pkg::IDX_IRQ_MASK, 16'h0007);
    check({15'h0, irq}, 16'h0000);
    bus(1'b1, cable_diag_pkg::IDX_IRQ_STATUS, 16'h000f);
    rdchk(cable_diag_pkg::IDX_IRQ_STATUS, 16'h0000);
    bus(1'b1, cable_diag_pkg::IDX_CAPTURE_CTRL, 16'h0003);
    exp_r = '{default: 16'h0000};
    chk_all();
    rdchk(10'h3ff, 16'h0000);
    wrap_up();
  end
endmodule : cable_diag_amplitude_results_tb
